// *** core/abr_pkg.sv ***
// Shared constants and types for the block RAM pipeline controller.
package abr_pkg;

  // ------------------------------------------------------------
  // Pipeline depths
  // ------------------------------------------------------------
  localparam logic [1:0] ABR_PIPE_DEPTH = 2'h2;
  localparam logic [1:0] ABR_SKID_DEPTH = 2'h2;

  // ------------------------------------------------------------
  // AXI encodings
  // ------------------------------------------------------------
  localparam logic [1:0] ABR_BURST_FIXED = 2'h0;
  localparam logic [1:0] ABR_BURST_INCR  = 2'h1;
  localparam logic [1:0] ABR_BURST_WRAP  = 2'h2;
  localparam logic [1:0] ABR_RESP_OKAY   = 2'h0;

  // Smallest length field of a read burst that may merge with the next one (three beats).
  localparam logic [7:0] ABR_CONT_MIN_LEN = 8'h02;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [1:0] ABR_CNT_RST   = 2'h0;
  localparam logic       ABR_READY_RST = 1'b1;

  // ------------------------------------------------------------
  // Owner of the shared memory port in single-port mode
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ABR_OWN_NONE,
    ABR_OWN_WR,
    ABR_OWN_RD
  } abr_own_e;

endpackage

// *** core/abr_pipe2.sv ***
// Two-entry in-order holding queue for address and identifier words.
module abr_pipe2
  import abr_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         push,
  input  wire logic [W-1:0] din,
  input  wire logic         pop,
  output logic      [W-1:0] dout,
  output logic      [1:0]   count
);

  logic [W-1:0] slot_q [2];
  logic [1:0]   cnt_q;

  assign dout  = slot_q[0];
  assign count = cnt_q;

  // ------------------------------------------------------------
  // Storage: slot 0 is always the oldest entry.
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
      cnt_q     <= ABR_CNT_RST;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'h0) begin
            slot_q[0] <= din;
          end else begin
            slot_q[1] <= din;
          end
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          slot_q[0] <= slot_q[1];
          cnt_q     <= cnt_q - 2'h1;
        end
        2'b11: begin
          if (cnt_q == 2'h1) begin
            slot_q[0] <= din;
          end else begin
            slot_q[0] <= slot_q[1];
            slot_q[1] <= din;
          end
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

endmodule

// *** core/abr_ctrl.sv ***
// AXI4 slave that runs pipelined read and write bursts onto block RAM ports.
// ------------------------------------------------------------
module abr_ctrl
  import abr_pkg::*;
#(
  parameter int DATA_W      = 32,
  parameter int AXI_AW      = 32,
  parameter int ID_W        = 4,
  parameter int MEM_AW      = 10,
  parameter bit SINGLE_PORT = 1'b0,
  parameter bit ECC         = 1'b0
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic [ID_W-1:0]     s_axi_awid,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic [7:0]          s_axi_awlen,
  input  wire logic [2:0]          s_axi_awsize,
  input  wire logic [1:0]          s_axi_awburst,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                s_axi_wlast,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic      [ID_W-1:0]     s_axi_bid,
  output logic      [1:0]          s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ID_W-1:0]     s_axi_arid,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic [7:0]          s_axi_arlen,
  input  wire logic [2:0]          s_axi_arsize,
  input  wire logic [1:0]          s_axi_arburst,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic      [ID_W-1:0]     s_axi_rid,
  output logic      [DATA_W-1:0]   s_axi_rdata,
  output logic      [1:0]          s_axi_rresp,
  output logic                     s_axi_rlast,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic                     mem_a_en,
  output logic      [DATA_W/8-1:0] mem_a_we,
  output logic      [MEM_AW-1:0]   mem_a_word_address,
  output logic      [DATA_W-1:0]   mem_a_wdata,
  input  wire logic [DATA_W-1:0]   mem_a_rdata,
  output logic                     mem_b_en,
  output logic      [MEM_AW-1:0]   mem_b_word_address,
  input  wire logic [DATA_W-1:0]   mem_b_rdata
);

  localparam int         STRB_W   = DATA_W / 8;
  localparam int         OFF      = $clog2(STRB_W);
  localparam int         QW       = ID_W + AXI_AW + 8 + 3 + 2;
  localparam logic [2:0] SIZE_FULL = 3'(OFF);
  localparam bit         EARLY_OK = !SINGLE_PORT && !ECC;

  // ------------------------------------------------------------
  // Address helpers
  // ------------------------------------------------------------
  function automatic logic [AXI_AW-1:0] next_addr(input logic [AXI_AW-1:0] a,
                                                  input logic [7:0]        len,
                                                  input logic [2:0]        size,
                                                  input logic [1:0]        burst);
    logic [AXI_AW-1:0] step;
    logic [AXI_AW-1:0] mask;
    step = AXI_AW'(1) << size;
    mask = ((AXI_AW'(len) + AXI_AW'(1)) << size) - AXI_AW'(1);
    case (burst)
      ABR_BURST_FIXED: next_addr = a;
      ABR_BURST_WRAP:  next_addr = (a & ~mask) | (((a & ~(step - AXI_AW'(1))) + step) & mask);
      default:         next_addr = (a & ~(step - AXI_AW'(1))) + step;
    endcase
  endfunction

  function automatic logic [MEM_AW-1:0] word_of(input logic [AXI_AW-1:0] a);
    word_of = a[MEM_AW+OFF-1:OFF];
  endfunction

  // ------------------------------------------------------------
  // Address pipelines
  // ------------------------------------------------------------
  logic [QW-1:0]     aw_head, ar_head;
  logic [1:0]        awq_cnt, arq_cnt, bq_cnt;
  logic              aw_hs, ar_hs, awq_pop, arq_pop, bq_push, bq_pop;
  logic [ID_W-1:0]   bq_din, bq_head;
  logic [ID_W-1:0]   awh_id, arh_id;
  logic [AXI_AW-1:0] awh_addr, arh_addr;
  logic [7:0]        awh_len, arh_len;
  logic [2:0]        awh_size, arh_size;
  logic [1:0]        awh_burst, arh_burst;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign {awh_id, awh_addr, awh_len, awh_size, awh_burst} = aw_head;
  assign {arh_id, arh_addr, arh_len, arh_size, arh_burst} = ar_head;

  abr_pipe2 #(.W(QW)) u_awq (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .push    (aw_hs),
    .din     ({s_axi_awid, s_axi_awaddr, s_axi_awlen, s_axi_awsize, s_axi_awburst}),
    .pop     (awq_pop),
    .dout    (aw_head),
    .count   (awq_cnt)
  );

  abr_pipe2 #(.W(QW)) u_arq (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .push    (ar_hs),
    .din     ({s_axi_arid, s_axi_araddr, s_axi_arlen, s_axi_arsize, s_axi_arburst}),
    .pop     (arq_pop),
    .dout    (ar_head),
    .count   (arq_cnt)
  );

  abr_pipe2 #(.W(ID_W)) u_bq (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .push    (bq_push),
    .din     (bq_din),
    .pop     (bq_pop),
    .dout    (bq_head),
    .count   (bq_cnt)
  );

  // ------------------------------------------------------------
  // Shared-port ownership
  // ------------------------------------------------------------
  abr_own_e own_q;
  logic     last_rd_q;
  logic     wok, rok;

  assign wok = !SINGLE_PORT || (own_q == ABR_OWN_WR);
  assign rok = !SINGLE_PORT || (own_q == ABR_OWN_RD);

  // ------------------------------------------------------------
  // Write engine
  // ------------------------------------------------------------
  logic              wact_q, held_q, wready_q;
  logic [AXI_AW-1:0] waddr_q;
  logic [7:0]        wcnt_q, wlen_q;
  logic [2:0]        wsize_q;
  logic [1:0]        wburst_q;
  logic [ID_W-1:0]   wid_q;
  logic [DATA_W-1:0] held_data_q;
  logic [STRB_W-1:0] held_strb_q;
  logic [1:0]        wout_q, wout_d;
  logic              w_hs, w_beat, w_done, w_cont, w_start, w_load, h_beat, h_done;
  logic              wact_d, held_d;

  assign w_hs    = s_axi_wvalid & wready_q;
  assign w_beat  = w_hs & wact_q;
  assign w_done  = w_beat & (wcnt_q == 8'h0);
  assign w_cont  = w_done && (awq_cnt != 2'h0) && (!SINGLE_PORT || arq_cnt == 2'h0);
  assign w_start = !wact_q && (awq_cnt != 2'h0) && wok;
  assign w_load  = w_start | w_cont;
  assign h_beat  = w_start & held_q;
  assign h_done  = h_beat & (awh_len == 8'h0);
  assign awq_pop = w_load;
  assign bq_push = w_done | h_done;
  assign bq_din  = w_done ? wid_q : awh_id;

  always_comb begin
    wact_d = wact_q;
    if (w_done) begin
      wact_d = 1'b0;
    end
    if (w_load) begin
      wact_d = !h_done;
    end
    held_d = (held_q & !h_beat) | (w_hs & !wact_q);
    wout_d = wout_q + {1'b0, aw_hs} - {1'b0, s_axi_bvalid & s_axi_bready};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wact_q   <= 1'b0;
      waddr_q  <= '0;
      wcnt_q   <= 8'h0;
      wlen_q   <= 8'h0;
      wsize_q  <= 3'h0;
      wburst_q <= ABR_BURST_FIXED;
      wid_q    <= '0;
    end else begin
      wact_q <= wact_d;
      if (w_load) begin
        wid_q    <= awh_id;
        wlen_q   <= awh_len;
        wsize_q  <= awh_size;
        wburst_q <= awh_burst;
        if (h_beat) begin
          waddr_q <= next_addr(awh_addr, awh_len, awh_size, awh_burst);
          wcnt_q  <= awh_len - 8'h1;
        end else begin
          waddr_q <= awh_addr;
          wcnt_q  <= awh_len;
        end
      end else if (w_beat) begin
        waddr_q <= next_addr(waddr_q, wlen_q, wsize_q, wburst_q);
        wcnt_q  <= wcnt_q - 8'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      held_q      <= 1'b0;
      held_data_q <= '0;
      held_strb_q <= '0;
      wready_q    <= 1'b0;
    end else begin
      held_q <= held_d;
      if (w_hs & !wact_q) begin
        held_data_q <= s_axi_wdata;
        held_strb_q <= s_axi_wstrb;
      end
      wready_q <= wact_d | (EARLY_OK & !wact_d & !held_d & (awq_cnt == 2'h0) & !aw_hs);
    end
  end

  // ------------------------------------------------------------
  // Write address admission and response
  // ------------------------------------------------------------
  logic awready_q, bvalid_q;
  logic [ID_W-1:0] bid_q;

  assign bq_pop = (!bvalid_q | s_axi_bready) & (bq_cnt != 2'h0);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wout_q    <= ABR_CNT_RST;
      awready_q <= ABR_READY_RST;
      bvalid_q  <= 1'b0;
      bid_q     <= '0;
    end else begin
      wout_q    <= wout_d;
      awready_q <= (wout_d < ABR_PIPE_DEPTH);
      if (bq_pop) begin
        bvalid_q <= 1'b1;
        bid_q    <= bq_head;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Read engine
  // ------------------------------------------------------------
  logic              ract_q, rthr_q, rfly_q, rfly_last_q, sk1_v_q, rvalid_q;
  logic [AXI_AW-1:0] raddr_q;
  logic [7:0]        rcnt_q, rlen_q;
  logic [2:0]        rsize_q;
  logic [1:0]        rburst_q, occ;
  logic [ID_W-1:0]   rid_q, rfly_id_q;
  logic              r_pop, r_credit, r_issue, r_end, r_qual, r_cont, r_start, r_load;

  assign r_pop    = rvalid_q & s_axi_rready;
  assign occ      = {1'b0, rfly_q} + {1'b0, rvalid_q} + {1'b0, sk1_v_q};
  assign r_credit = (occ - {1'b0, r_pop}) < ABR_SKID_DEPTH;
  assign r_issue  = ract_q & rok & r_credit;
  assign r_end    = r_issue & (rcnt_q == 8'h0);
  assign r_qual   = (rlen_q >= ABR_CONT_MIN_LEN) && (rsize_q == SIZE_FULL)
                    && (rburst_q != ABR_BURST_FIXED) && !rthr_q;
  assign r_cont   = r_end && (arq_cnt != 2'h0) && r_qual
                    && (!SINGLE_PORT || awq_cnt == 2'h0);
  assign r_start  = !ract_q && (arq_cnt != 2'h0) && rok;
  assign r_load   = r_start | r_cont;
  assign arq_pop  = r_load;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ract_q   <= 1'b0;
      rthr_q   <= 1'b0;
      raddr_q  <= '0;
      rcnt_q   <= 8'h0;
      rlen_q   <= 8'h0;
      rsize_q  <= 3'h0;
      rburst_q <= ABR_BURST_FIXED;
      rid_q    <= '0;
    end else begin
      if (r_load) begin
        ract_q   <= 1'b1;
        rthr_q   <= 1'b0;
        raddr_q  <= arh_addr;
        rcnt_q   <= arh_len;
        rlen_q   <= arh_len;
        rsize_q  <= arh_size;
        rburst_q <= arh_burst;
        rid_q    <= arh_id;
      end else begin
        if (r_end) begin
          ract_q <= 1'b0;
        end
        if (ract_q & rok & !r_credit) begin
          rthr_q <= 1'b1;
        end
        if (r_issue) begin
          raddr_q <= next_addr(raddr_q, rlen_q, rsize_q, rburst_q);
          rcnt_q  <= rcnt_q - 8'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Read data skid buffer: stage 0 drives the read channel.
  // ------------------------------------------------------------
  logic [DATA_W-1:0] rin_data, sk1_data_q, rdata_q;
  logic [ID_W-1:0]   sk1_id_q, rid_out_q;
  logic              sk1_last_q, rlast_q;

  assign rin_data = SINGLE_PORT ? mem_a_rdata : mem_b_rdata;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rfly_q      <= 1'b0;
      rfly_last_q <= 1'b0;
      rfly_id_q   <= '0;
    end else begin
      rfly_q      <= r_issue;
      rfly_last_q <= r_end;
      rfly_id_q   <= rid_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rlast_q    <= 1'b0;
      rid_out_q  <= '0;
      sk1_v_q    <= 1'b0;
      sk1_data_q <= '0;
      sk1_last_q <= 1'b0;
      sk1_id_q   <= '0;
    end else if (r_pop | !rvalid_q) begin
      if (sk1_v_q) begin
        rvalid_q  <= 1'b1;
        rdata_q   <= sk1_data_q;
        rlast_q   <= sk1_last_q;
        rid_out_q <= sk1_id_q;
        sk1_v_q   <= rfly_q;
      end else begin
        rvalid_q  <= rfly_q;
        rdata_q   <= rfly_q ? rin_data : rdata_q;
        rlast_q   <= rfly_q ? rfly_last_q : rlast_q;
        rid_out_q <= rfly_q ? rfly_id_q : rid_out_q;
      end
      if (rfly_q) begin
        sk1_data_q <= rin_data;
        sk1_last_q <= rfly_last_q;
        sk1_id_q   <= rfly_id_q;
      end
    end else if (rfly_q) begin
      sk1_v_q    <= 1'b1;
      sk1_data_q <= rin_data;
      sk1_last_q <= rfly_last_q;
      sk1_id_q   <= rfly_id_q;
    end
  end

  logic arready_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= ABR_READY_RST;
    end else begin
      arready_q <= ((arq_cnt + {1'b0, ar_hs} - {1'b0, arq_pop}) < ABR_PIPE_DEPTH);
    end
  end

  // ------------------------------------------------------------
  // Single-port arbitration with least-recently-served tie break
  // ------------------------------------------------------------
  logic w_req, r_req;

  assign w_req = !wact_q && (awq_cnt != 2'h0);
  assign r_req = !ract_q && (arq_cnt != 2'h0);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      own_q     <= ABR_OWN_NONE;
      last_rd_q <= 1'b0;
    end else if (SINGLE_PORT) begin
      case (own_q)
        ABR_OWN_NONE: begin
          if (w_req && (!r_req || last_rd_q)) begin
            own_q     <= ABR_OWN_WR;
            last_rd_q <= 1'b0;
          end else if (r_req) begin
            own_q     <= ABR_OWN_RD;
            last_rd_q <= 1'b1;
          end
        end
        ABR_OWN_WR: begin
          if ((w_done & !w_cont) | h_done) begin
            own_q <= ABR_OWN_NONE;
          end
        end
        ABR_OWN_RD: begin
          if (r_end & !r_cont) begin
            own_q <= ABR_OWN_NONE;
          end
        end
        default: begin
          own_q <= ABR_OWN_NONE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registered memory ports
  // ------------------------------------------------------------
  logic              mem_a_en_q, mem_b_en_q;
  logic [STRB_W-1:0] mem_a_we_q;
  logic [MEM_AW-1:0] mem_a_addr_q, mem_b_addr_q;
  logic [DATA_W-1:0] mem_a_wdata_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_a_en_q    <= 1'b0;
      mem_a_we_q    <= '0;
      mem_a_addr_q  <= '0;
      mem_a_wdata_q <= '0;
    end else begin
      mem_a_en_q <= w_beat | h_beat | (SINGLE_PORT & r_issue);
      mem_a_we_q <= '0;
      if (w_beat) begin
        mem_a_we_q    <= s_axi_wstrb;
        mem_a_addr_q  <= word_of(waddr_q);
        mem_a_wdata_q <= s_axi_wdata;
      end else if (h_beat) begin
        mem_a_we_q    <= held_strb_q;
        mem_a_addr_q  <= word_of(awh_addr);
        mem_a_wdata_q <= held_data_q;
      end else if (SINGLE_PORT & r_issue) begin
        mem_a_addr_q <= word_of(raddr_q);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_b_en_q   <= 1'b0;
      mem_b_addr_q <= '0;
    end else begin
      mem_b_en_q <= !SINGLE_PORT & r_issue;
      if (!SINGLE_PORT & r_issue) begin
        mem_b_addr_q <= word_of(raddr_q);
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic [1:0] resp_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resp_q <= ABR_RESP_OKAY;
    end else begin
      resp_q <= ABR_RESP_OKAY;
    end
  end

  assign s_axi_awready      = awready_q;
  assign s_axi_wready       = wready_q;
  assign s_axi_bid          = bid_q;
  assign s_axi_bresp        = resp_q;
  assign s_axi_bvalid       = bvalid_q;
  assign s_axi_arready      = arready_q;
  assign s_axi_rid          = rid_out_q;
  assign s_axi_rdata        = rdata_q;
  assign s_axi_rresp        = resp_q;
  assign s_axi_rlast        = rlast_q;
  assign s_axi_rvalid       = rvalid_q;
  assign mem_a_en           = mem_a_en_q;
  assign mem_a_we           = mem_a_we_q;
  assign mem_a_word_address = mem_a_addr_q;
  assign mem_a_wdata        = mem_a_wdata_q;
  assign mem_b_en           = mem_b_en_q;
  assign mem_b_word_address = mem_b_addr_q;

endmodule

// *** tb/abr_mem_model.sv ***
// Dual-port block RAM model with combinational read: the word follows the address in the same cycle.
module abr_mem_model
  import abr_pkg::*;
#(
  parameter int DW = 32,
  parameter int AW = 10
) (
  input  wire logic            clk_sys,
  input  wire logic            a_en,
  input  wire logic [DW/8-1:0] a_we,
  input  wire logic [AW-1:0]   a_adr,
  input  wire logic [DW-1:0]   a_wd,
  output logic      [DW-1:0]   a_rd,
  input  wire logic            b_en,
  input  wire logic [AW-1:0]   b_adr,
  output logic      [DW-1:0]   b_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [2**AW];
  // The word of a registered enable stands until the next edge; an idle port shows the inverse.
  assign a_rd = a_en ? mem[a_adr] : ~mem[a_adr];
  assign b_rd = b_en ? mem[b_adr] : ~mem[b_adr];
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < DW/8; i++) begin
      if (a_en && a_we[i]) begin
        mem[a_adr][8*i+:8] <= a_wd[8*i+:8];
      end
    end
  end
endmodule

// *** tb/abr_ctrl_assertions.sv ***
// Port checker for the block RAM pipeline controller.
module abr_ctrl_assertions
  import abr_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic [7:0]        s_axi_awlen,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wlast,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rlast,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              mem_a_en,
  input wire logic              mem_b_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic aw_hs, w_hs, b_hs, ar_hs, r_hs;
  int   aw_n, w_cov, wl_n, rd_n, wa_n;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs  = s_axi_wvalid & s_axi_wready;
  assign b_hs  = s_axi_bvalid & s_axi_bready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign r_hs  = s_axi_rvalid & s_axi_rready & s_axi_rlast;
  // Outstanding writes, uncovered beats, finished bursts, open reads, unwritten beats.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {aw_n, w_cov, wl_n, rd_n, wa_n} <= '0;
    end else begin
      aw_n  <= aw_n + aw_hs - b_hs;
      w_cov <= w_cov + (aw_hs ? s_axi_awlen + 1 : 0) - w_hs;
      wl_n  <= wl_n + (w_hs & s_axi_wlast) - b_hs;
      rd_n  <= rd_n + ar_hs - r_hs;
      wa_n  <= wa_n + w_hs - mem_a_en;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_held;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  chk_reset_idle: assert property ($rose(rst_b) |-> s_axi_awready && s_axi_arready
    && !s_axi_rvalid && !s_axi_bvalid && !mem_a_en && !mem_b_en) else $error("not idle");
  chk_stall_hold: assert property (s_held |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rlast)) else $error("read moved in stall");
  chk_aw_full: assert property (aw_hs |-> aw_n < 2) else $error("third write");
  chk_early_one: assert property (w_cov >= -1) else $error("two early beats");
  chk_resp_order: assert property (s_axi_bvalid |-> wl_n > 0) else $error("early resp");
  chk_wport_cause: assert property (mem_a_en |-> wa_n > 0) else $error("stray write");
  chk_rport_idle: assert property (mem_b_en |-> rd_n > 0) else $error("stray read");
  chk_rdata_cause: assert property (s_axi_rvalid |-> rd_n > 0) else $error("stray data");
endmodule

bind abr_ctrl abr_ctrl_assertions #(.DATA_W(DATA_W)) u_chk (.*);

// *** tb/abr_ctrl_tb.sv ***
// Self-checking testbench for the block RAM pipeline controller.
module abr_ctrl_tb
  import abr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wlast, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rlast, s_axi_rvalid, s_axi_rready, mem_a_en, mem_b_en;
  logic [1:0]  s_axi_awburst, s_axi_arburst, s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awsize, s_axi_arsize;
  logic [3:0]  s_axi_awid, s_axi_bid, s_axi_arid, s_axi_rid, s_axi_wstrb, mem_a_we;
  logic [7:0]  s_axi_awlen, s_axi_arlen;
  logic [9:0]  mem_a_word_address, mem_b_word_address;
  logic [31:0] s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_rdata, mem_a_wdata;
  logic [31:0] mem_a_rdata, mem_b_rdata, shadow [1024];
  int          bad_count, samples_checked;

  abr_ctrl i_dut (.*);
  abr_mem_model i_mem (.clk_sys(clk_sys), .a_en(mem_a_en), .a_we(mem_a_we),
    .a_adr(mem_a_word_address), .a_wd(mem_a_wdata), .a_rd(mem_a_rdata),
    .b_en(mem_b_en), .b_adr(mem_b_word_address), .b_rd(mem_b_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic awr(input logic [31:0] a, input logic [7:0] len);
    @(negedge clk_sys);
    {s_axi_awvalid, s_axi_awaddr, s_axi_awlen, s_axi_awid} = {1'b1, a, len, len[3:0]};
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    @(negedge clk_sys);
    s_axi_awvalid = 1'b0;
  endtask

  task automatic wbeats(input logic [31:0] a, input logic [7:0] len, input logic [31:0] d);
    for (int i = 0; i <= len; i++) begin
      @(negedge clk_sys);
      {s_axi_wvalid, s_axi_wlast, s_axi_wdata} = {1'b1, i == len, d + i};
      do @(posedge clk_sys); while (s_axi_wready !== 1'b1);
      shadow[a[11:2] + i] = d + i;
    end
    @(negedge clk_sys);
    s_axi_wvalid = 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] len, input logic [1:0] bu,
                    input bit st);
    logic [9:0] w, m;
    int         k;
    w = a[11:2];
    m = {2'h0, len};
    k = 0;
    fork
      begin
        @(negedge clk_sys);
        {s_axi_arvalid, s_axi_araddr, s_axi_arlen, s_axi_arburst} = {1'b1, a, len, bu};
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        @(negedge clk_sys);
        s_axi_arvalid = 1'b0;
      end
      while (k <= len) begin
        @(negedge clk_sys);
        s_axi_rready = !st || !s_axi_rready;
        @(posedge clk_sys);
        if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
          chk(shadow[bu == ABR_BURST_WRAP ? (w & ~m) | ((w + k) & m) : w + k], s_axi_rdata);
          chk(k == len, s_axi_rlast);
          chk({s_axi_arid, ABR_RESP_OKAY}, {s_axi_rid, s_axi_rresp});
          k++;
        end
      end
    join
    @(negedge clk_sys);
    s_axi_rready = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic t_burst();
    chk(32'h1, s_axi_awready & s_axi_arready & !s_axi_rvalid & !s_axi_bvalid);
    fork
      awr(32'h100, 8'h7);
      wbeats(32'h100, 8'h7, 32'ha000);
    join
    rd(32'h100, 8'h7, ABR_BURST_INCR, 1'b1);
    rd(32'h108, 8'h3, ABR_BURST_WRAP, 1'b0);
    rd(32'h11c, 8'h0, ABR_BURST_INCR, 1'b0);
    $display("burst test done");
  endtask

  task automatic t_early();
    fork
      wbeats(32'h300, 8'h3, 32'hb000);
      begin
        repeat (4) @(posedge clk_sys);
        chk(32'h0, s_axi_wready);
        awr(32'h300, 8'h3);
      end
    join
    rd(32'h300, 8'h3, ABR_BURST_INCR, 1'b0);
    $display("early data test done");
  endtask

  task automatic t_awfull();
    fork
      for (int i = 0; i < 3; i++) awr(32'h200 + 4 * i, 8'h0);
      begin
        repeat (8) @(posedge clk_sys);
        chk(32'h0, s_axi_awready);
        for (int i = 0; i < 3; i++) wbeats(32'h200 + 4 * i, 8'h0, 32'hc000 + i);
      end
    join
    rd(32'h200, 8'h2, ABR_BURST_INCR, 1'b0);
    $display("write pipeline test done");
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_wlast, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awid, s_axi_awaddr, s_axi_awlen, s_axi_wdata} = '0;
    {s_axi_arid, s_axi_araddr, s_axi_arlen} = '0;
    {s_axi_awsize, s_axi_arsize, s_axi_wstrb, s_axi_bready} = {3'h2, 3'h2, 4'hf, 1'b1};
    {s_axi_awburst, s_axi_arburst} = {ABR_BURST_INCR, ABR_BURST_INCR};
    {bad_count, samples_checked} = '0;
    rst_b = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    @(posedge clk_sys);
    t_burst();
    t_early();
    t_awfull();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule
